// ---- core/fsoam_defs.svh ----
// Constants of the flash sector and one-time-programmable address map
`ifndef FSOAM_DEFS_SVH
`define FSOAM_DEFS_SVH

// =====================================================================
// Register offsets
`define FSOAM_REG_CONFIG 4'h0
`define FSOAM_REG_BANK 4'h1
`define FSOAM_REG_PROT 4'h2
`define FSOAM_REG_STATUS 4'h3
`define FSOAM_REG_IRQ_STAT 4'h4
`define FSOAM_REG_IRQ_CLR 4'h5
`define FSOAM_REG_IRQ_EN 4'h6
`define FSOAM_REG_LAST_SECT 4'h7

// =====================================================================
// Field positions
`define FSOAM_CFG_FREEZE 0
`define FSOAM_CFG_LAYOUT_LO 1
`define FSOAM_CFG_LARGE 3
`define FSOAM_BANK_EXT 8
`define FSOAM_PROT_HI_LO 16
`define FSOAM_PROT_EN 31
`define FSOAM_ST_PERR 0
`define FSOAM_ST_EERR 1
`define FSOAM_EVT_PROG_DONE 0
`define FSOAM_EVT_PROG_ERR 1
`define FSOAM_EVT_ERASE_DONE 2
`define FSOAM_EVT_ERASE_ERR 3

// =====================================================================
// Reset values
`define FSOAM_RST_BANK 8'h00
`define FSOAM_RST_FREEZE 1'b0
`define FSOAM_RST_LARGE 1'b1
`define FSOAM_RST_PROT 32'h0000_0000

// =====================================================================
// Link opcodes
`define FSOAM_OP_ID_READ 8'h9F
`define FSOAM_OP_PROG 8'h02
`define FSOAM_OP_ERASE 8'hD8
`define FSOAM_OP_OTP_PROG 8'h42
`define FSOAM_OP_OTP_READ 8'h4B
`define FSOAM_OP_CLR_STATUS 8'h30

// =====================================================================
// Array geometry
`define FSOAM_SMALL_SPAN 26'h004_0000
`define FSOAM_SMALL_COUNT 10'h020
`define FSOAM_TOP_BASE_L 26'h3FC_0000
`define FSOAM_TOP_BASE_S 26'h1FC_0000
`define FSOAM_BIG_COUNT_L 10'h1FE
`define FSOAM_BIG_COUNT_S 10'h0FE
`define FSOAM_OTP_BYTES 2048
`define FSOAM_OTP_RANDOM_END 11'h010
`define FSOAM_OTP_LOCK_0 11'h010
`define FSOAM_OTP_LOCK_1 11'h011
`define FSOAM_OTP_LOCK_2 11'h012
`define FSOAM_OTP_LOCK_3 11'h013
`define FSOAM_ERASED_BYTE 8'hFF

`endif

// ---- core/fsoam_pkg.sv ----
// Types of the flash sector and one-time-programmable address map
package fsoam_pkg;

  // =====================================================================
  // Sector layout options
  typedef enum logic [1:0] {
    LAYOUT_BOTTOM = 2'h0,
    LAYOUT_TOP = 2'h1,
    LAYOUT_UNIFORM = 2'h2
  } fsoam_layout_e;

  // =====================================================================
  // Link frame states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_WRITE = 5'h04,
    ST_READ = 5'h08,
    ST_SKIP = 5'h10
  } fsoam_state_e;

endpackage

// ---- core/fsoam_sector_map.sv ----
// Byte address to erase sector index for each layout option
`timescale 1ns/100ps
`include "fsoam_defs.svh"

module fsoam_sector_map (
  input wire logic [25:0] byteAddr,
  input wire fsoam_pkg::fsoam_layout_e layout,
  input wire logic largeDensity,
  output logic [9:0] sectorIdx,
  output logic inRange
);

  // =====================================================================
  // Hybrid bottom: 32 small sectors first, big ones after
  wire logic bottomSmall;
  wire logic [25:0] diffBottom;
  wire logic [9:0] idxBottom;
  assign bottomSmall = byteAddr < `FSOAM_SMALL_SPAN;
  assign diffBottom = byteAddr - `FSOAM_SMALL_SPAN;
  assign idxBottom = bottomSmall ? {5'h00, byteAddr[17:13]} :
                     `FSOAM_SMALL_COUNT + {1'b0, diffBottom[25:17]};

  // =====================================================================
  // Hybrid top: big sectors from zero, small ones at the top
  wire logic [25:0] topBase;
  wire logic [9:0] bigCount;
  wire logic topSmall;
  wire logic [25:0] diffTop;
  wire logic [9:0] idxTop;
  assign topBase = largeDensity ? `FSOAM_TOP_BASE_L : `FSOAM_TOP_BASE_S;
  assign bigCount = largeDensity ? `FSOAM_BIG_COUNT_L : `FSOAM_BIG_COUNT_S;
  assign topSmall = byteAddr >= topBase;
  assign diffTop = byteAddr - topBase;
  assign idxTop = topSmall ? bigCount + {5'h00, diffTop[17:13]} :
                  {1'b0, byteAddr[25:17]};

  // =====================================================================
  // Uniform 512 kbyte sectors, then option select
  wire logic [9:0] idxUniform;
  assign idxUniform = {3'h0, byteAddr[25:19]};
  assign sectorIdx = (layout == fsoam_pkg::LAYOUT_BOTTOM) ? idxBottom :
                     (layout == fsoam_pkg::LAYOUT_TOP) ? idxTop :
                     idxUniform;
  assign inRange = largeDensity | ~byteAddr[25];

endmodule

// ---- core/fsoam_otp_store.sv ----
// One-time-programmable space with random number, lock bytes and freeze
`timescale 1ns/100ps
`include "fsoam_defs.svh"

module fsoam_otp_store #(
  // Factory random number; default value is arbitrary
  parameter logic [127:0] RANDOM_VALUE =
    128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic progEn,
  input wire logic [10:0] addr,
  input wire logic [7:0] progData,
  input wire logic freeze,
  output logic [7:0] rdData,
  output logic progDone,
  output logic progRefused
);

  logic [7:0] mem [0:`FSOAM_OTP_BYTES-1];
  logic [7:0] rdData_q;
  logic progDone_q;
  logic progRefused_q;

  // =====================================================================
  // Delivery contents: random number, everything else erased
  initial begin
    for (int i = 0; i < `FSOAM_OTP_BYTES; i++) begin
      mem[i] = (i < 16) ? RANDOM_VALUE[8*i +: 8] :
               `FSOAM_ERASED_BYTE;
    end
  end

  // =====================================================================
  // Protection decode
  wire logic [31:0] lockWord;
  wire logic [5:0] region;
  wire logic regionLocked;
  wire logic randomHit;
  wire logic refuse;
  assign lockWord = {mem[`FSOAM_OTP_LOCK_3], mem[`FSOAM_OTP_LOCK_2],
                     mem[`FSOAM_OTP_LOCK_1], mem[`FSOAM_OTP_LOCK_0]};
  assign region = addr[10:5];
  // Regions above 31 have no lock bit and stay open
  assign regionLocked = ~region[5] & ~lockWord[region[4:0]];
  assign randomHit = addr < `FSOAM_OTP_RANDOM_END;
  assign refuse = freeze | randomHit | regionLocked;

  // Programming only clears bits, as in flash cells
  always @(posedge clk) begin
    if (progEn && !refuse) begin
      mem[addr] <= mem[addr] & progData;
    end
  end

  // Read data and outcome pulses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdData_q <= 8'h00;
      progDone_q <= 1'b0;
      progRefused_q <= 1'b0;
    end else begin
      rdData_q <= mem[addr];
      progDone_q <= progEn & ~refuse;
      progRefused_q <= progEn & refuse;
    end
  end

  assign rdData = rdData_q;
  assign progDone = progDone_q;
  assign progRefused = progRefused_q;

endmodule

// ---- core/fsoam_top.sv ----
// Serial flash address map: sector decode, protection and OTP access
`timescale 1ns/100ps
`include "fsoam_defs.svh"

// Function
// - Uniform: 512 kbyte sectors, 128 or 64
// - Bottom: 32 small sectors low, rest big
// - Top: big sectors low, 32 small high
// - Identification read returns fixed read-only space
// - OTP space 2048 bytes, 64 regions
// - Random number bytes refuse programming
// - Lock bytes block programming of regions 0 to 31
// - Lock bit zero means locked, ascending order
// - Reserved bytes stay programmable by host
// - Delivery state is random number, all other bytes erased
// - Freeze bit blocks all OTP programming
// - Low nibble on first quad, high on second
// - Protected program sets program error flag
// - Reset clears bank, selects 24-bit addressing
module fsoam_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdData,
  input wire logic sckPin,
  input wire logic csPinN,
  input wire logic [7:0] ioIn,
  output logic [7:0] ioOut,
  output logic [7:0] ioOe,
  output logic irq
);

  // =====================================================================
  // Identification space, contents arbitrary
  function automatic logic [7:0] idByte(input logic [3:0] idx);
    case (idx)
      4'h0: idByte = 8'h5A;
      4'h1: idByte = 8'h21;
      4'h2: idByte = 8'h19;
      4'h3: idByte = 8'h4D;
      4'h4: idByte = 8'h01;
      4'h5: idByte = 8'h80;
      default: idByte = `FSOAM_ERASED_BYTE;
    endcase
  endfunction

  // =====================================================================
  // Link pin synchronisers and edge detect
  logic [9:0] linkMeta_q;
  logic [9:0] linkSync_q;
  logic sckPrev_q;
  wire logic sckSync;
  wire logic csSyncN;
  wire logic [7:0] ioSync;
  wire logic sckRise;
  wire logic sckFall;
  wire logic frameByte;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      linkMeta_q <= 10'h1FF;
      linkSync_q <= 10'h1FF;
      sckPrev_q <= 1'b0; // Idle clock low, no false edge
    end else begin
      linkMeta_q <= {sckPin, csPinN, ioIn};
      linkSync_q <= linkMeta_q;
      sckPrev_q <= linkSync_q[9];
    end
  end

  assign sckSync = linkSync_q[9];
  assign csSyncN = linkSync_q[8];
  // Bits 3:0 from the first quad lines, 7:4 from the second
  assign ioSync = linkSync_q[7:0];
  assign sckRise = sckSync & ~sckPrev_q;
  assign sckFall = ~sckSync & sckPrev_q;
  assign frameByte = sckRise & ~csSyncN;

  // =====================================================================
  // Configuration registers
  logic freeze_q;
  fsoam_pkg::fsoam_layout_e layout_q;
  logic large_q;
  logic [7:0] bank_q;
  logic extMode_q;
  logic [31:0] prot_q;
  logic [3:0] irqEn_q;

  wire logic wrConfig = regWr && (regAddr == `FSOAM_REG_CONFIG);
  wire logic wrBank = regWr && (regAddr == `FSOAM_REG_BANK);
  wire logic wrProt = regWr && (regAddr == `FSOAM_REG_PROT);
  wire logic wrStatus = regWr && (regAddr == `FSOAM_REG_STATUS);
  wire logic wrIrqClr = regWr && (regAddr == `FSOAM_REG_IRQ_CLR);
  wire logic wrIrqEn = regWr && (regAddr == `FSOAM_REG_IRQ_EN);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      freeze_q <= `FSOAM_RST_FREEZE;
      layout_q <= fsoam_pkg::LAYOUT_UNIFORM;
      large_q <= `FSOAM_RST_LARGE;
      bank_q <= `FSOAM_RST_BANK;
      extMode_q <= 1'b0;
      prot_q <= `FSOAM_RST_PROT;
      irqEn_q <= 4'h0;
    end else begin
      if (wrConfig) begin
        freeze_q <= regWrData[`FSOAM_CFG_FREEZE];
        layout_q <= fsoam_pkg::fsoam_layout_e'(
          regWrData[`FSOAM_CFG_LAYOUT_LO +: 2]);
        large_q <= regWrData[`FSOAM_CFG_LARGE];
      end
      if (wrBank) begin
        bank_q <= regWrData[7:0];
        extMode_q <= regWrData[`FSOAM_BANK_EXT];
      end
      if (wrProt) begin
        prot_q <= regWrData;
      end
      if (wrIrqEn) begin
        irqEn_q <= regWrData[3:0];
      end
    end
  end

  // =====================================================================
  // Frame decode and address assembly
  fsoam_pkg::fsoam_state_e state_q;
  logic [7:0] opcode_q;
  logic [2:0] byteCnt_q;
  logic [23:0] addrShift_q;
  logic [31:0] curAddr_q;

  wire logic [31:0] addrNext = {addrShift_q, ioSync};
  wire logic [2:0] addrLastCnt = extMode_q ? 3'h3 : 3'h2;
  wire logic addrLast = (state_q == fsoam_pkg::ST_ADDR) && frameByte &&
                        (byteCnt_q == addrLastCnt);
  // Legacy 24-bit addresses take their upper byte from the bank register
  wire logic [31:0] addrFull = extMode_q ? addrNext :
                               {bank_q, addrNext[23:0]};
  wire logic [31:0] mapAddr = (state_q == fsoam_pkg::ST_ADDR) ? addrFull :
                              curAddr_q;
  wire logic isProg = opcode_q == `FSOAM_OP_PROG;
  wire logic isErase = opcode_q == `FSOAM_OP_ERASE;
  wire logic isOtpProg = opcode_q == `FSOAM_OP_OTP_PROG;
  wire logic isOtpRead = opcode_q == `FSOAM_OP_OTP_READ;
  wire logic isIdRead = opcode_q == `FSOAM_OP_ID_READ;
  wire logic ioIsAddrOp = (ioSync == `FSOAM_OP_PROG) ||
                          (ioSync == `FSOAM_OP_ERASE) ||
                          (ioSync == `FSOAM_OP_OTP_PROG) ||
                          (ioSync == `FSOAM_OP_OTP_READ);

  // =====================================================================
  // Sector decode and main array protection
  wire logic [9:0] sectorIdx;
  wire logic inRange;
  wire logic [9:0] protLo = prot_q[9:0];
  wire logic [9:0] protHi = prot_q[`FSOAM_PROT_HI_LO +: 10];
  wire logic protHit = prot_q[`FSOAM_PROT_EN] &&
                       (sectorIdx >= protLo) && (sectorIdx <= protHi);
  wire logic mainBlocked = protHit | ~inRange | (|mapAddr[31:26]);

  fsoam_sector_map u_map (
    .byteAddr(mapAddr[25:0]),
    .layout(layout_q),
    .largeDensity(large_q),
    .sectorIdx(sectorIdx),
    .inRange(inRange)
  );

  // =====================================================================
  // OTP store and main array events
  wire logic otpDataByte = (state_q == fsoam_pkg::ST_WRITE) && frameByte;
  wire logic otpOutside = |curAddr_q[31:11];
  wire logic otpProgEn = otpDataByte && isOtpProg && !otpOutside;
  wire logic [7:0] otpRdData;
  wire logic otpDone;
  wire logic otpRefused;

  fsoam_otp_store u_otp (
    .clk(clk),
    .rst(rst),
    .progEn(otpProgEn),
    .addr(curAddr_q[10:0]),
    .progData(ioSync),
    .freeze(freeze_q),
    .rdData(otpRdData),
    .progDone(otpDone),
    .progRefused(otpRefused)
  );

  wire logic mainProg = otpDataByte && isProg;
  wire logic progErrEvt = (mainProg && mainBlocked) || otpRefused ||
                          (otpDataByte && isOtpProg && otpOutside);
  wire logic progDoneEvt = (mainProg && !mainBlocked) || otpDone;
  wire logic eraseEvt = addrLast && isErase;
  wire logic [3:0] events = {eraseEvt & mainBlocked, eraseEvt & ~mainBlocked,
                             progErrEvt, progDoneEvt};

  // =====================================================================
  // Link frame state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= fsoam_pkg::ST_IDLE;
      opcode_q <= 8'h00;
      byteCnt_q <= 3'h0;
      addrShift_q <= 24'h00_0000;
      curAddr_q <= 32'h0000_0000;
    end else if (csSyncN) begin
      state_q <= fsoam_pkg::ST_IDLE;
      byteCnt_q <= 3'h0;
    end else begin
      case (state_q)
        fsoam_pkg::ST_IDLE: begin
          if (frameByte) begin
            opcode_q <= ioSync;
            curAddr_q <= 32'h0000_0000;
            if (ioSync == `FSOAM_OP_ID_READ) begin
              state_q <= fsoam_pkg::ST_READ;
            end else if (ioIsAddrOp) begin
              state_q <= fsoam_pkg::ST_ADDR;
            end else begin
              state_q <= fsoam_pkg::ST_SKIP;
            end
          end
        end
        fsoam_pkg::ST_ADDR: begin
          if (frameByte) begin
            addrShift_q <= addrNext[23:0];
            byteCnt_q <= byteCnt_q + 3'h1;
          end
          if (addrLast) begin
            curAddr_q <= addrFull;
            state_q <= isErase ? fsoam_pkg::ST_SKIP :
                       isOtpRead ? fsoam_pkg::ST_READ :
                       fsoam_pkg::ST_WRITE;
          end
        end
        fsoam_pkg::ST_WRITE: begin
          if (frameByte) begin
            curAddr_q <= curAddr_q + 32'h1;
          end
        end
        fsoam_pkg::ST_READ: begin
          if (sckFall) begin
            curAddr_q <= curAddr_q + 32'h1;
          end
        end
        default: begin
          state_q <= fsoam_pkg::ST_SKIP;
        end
      endcase
    end
  end

  // =====================================================================
  // Read data onto the link, driven after falling edges
  logic [7:0] ioOut_q;
  logic [7:0] ioOe_q;
  wire logic [7:0] readByte = isIdRead ? idByte(curAddr_q[3:0]) : otpRdData;
  wire logic readShift = (state_q == fsoam_pkg::ST_READ) && sckFall &&
                         !csSyncN && (isIdRead || isOtpRead);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ioOut_q <= 8'h00;
      ioOe_q <= 8'h00;
    end else if (csSyncN) begin
      ioOe_q <= 8'h00;
    end else if (readShift) begin
      ioOut_q <= readByte;
      ioOe_q <= 8'hFF;
    end
  end

  // =====================================================================
  // Error flags, interrupt status and last sector
  logic pErr_q;
  logic eErr_q;
  logic [3:0] irqStat_q;
  logic [9:0] lastSect_q;
  logic irq_q;
  wire logic clrByCmd = (state_q == fsoam_pkg::ST_IDLE) && frameByte &&
                        (ioSync == `FSOAM_OP_CLR_STATUS);

  // Set wins over a clear in the same cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pErr_q <= 1'b0;
      eErr_q <= 1'b0;
      irqStat_q <= 4'h0;
      lastSect_q <= 10'h000;
      irq_q <= 1'b0;
    end else begin
      pErr_q <= progErrEvt | (pErr_q & ~clrByCmd &
                ~(wrStatus & regWrData[`FSOAM_ST_PERR]));
      eErr_q <= events[`FSOAM_EVT_ERASE_ERR] | (eErr_q & ~clrByCmd &
                ~(wrStatus & regWrData[`FSOAM_ST_EERR]));
      irqStat_q <= events | (irqStat_q & ~(wrIrqClr ? regWrData[3:0] : 4'h0));
      if (eraseEvt || mainProg) begin
        lastSect_q <= sectorIdx;
      end
      irq_q <= |(irqStat_q & irqEn_q);
    end
  end

  // =====================================================================
  // Register read port, data one cycle after the strobe
  logic [31:0] regRdData_q;
  wire logic [31:0] rdMux =
    (regAddr == `FSOAM_REG_CONFIG) ? {28'h0, large_q, layout_q, freeze_q} :
    (regAddr == `FSOAM_REG_BANK) ? {23'h0, extMode_q, bank_q} :
    (regAddr == `FSOAM_REG_PROT) ? prot_q :
    (regAddr == `FSOAM_REG_STATUS) ? {30'h0, eErr_q, pErr_q} :
    (regAddr == `FSOAM_REG_IRQ_STAT) ? {28'h0, irqStat_q} :
    (regAddr == `FSOAM_REG_IRQ_EN) ? {28'h0, irqEn_q} :
    (regAddr == `FSOAM_REG_LAST_SECT) ? {22'h0, lastSect_q} :
    32'h0000_0000;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      regRdData_q <= 32'h0000_0000;
    end else begin
      regRdData_q <= regRd ? rdMux : 32'h0000_0000;
    end
  end

  assign regRdData = regRdData_q;
  assign ioOut = ioOut_q;
  assign ioOe = ioOe_q;
  assign irq = irq_q;

endmodule

// ---- tb/fsoam_sva.sv ----
// Port checker for the flash address map top and its bind
`timescale 1ns/100ps
`include "fsoam_defs.svh"

module fsoam_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [31:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  input wire logic [31:0] regRdData,
  input wire logic sckPin,
  input wire logic csPinN,
  input wire logic [7:0] ioIn,
  input wire logic [7:0] ioOut,
  input wire logic [7:0] ioOe,
  input wire logic irq
);
  // ====
  // Mirrors of software writes
  logic cfgSeen_q, bankSeen_q;
  logic [3:0] cfg_q, en_q;
  logic [9:0] lim;
  wire cfgWr = regWr && regAddr == `FSOAM_REG_CONFIG;
  wire bankWr = regWr && regAddr == `FSOAM_REG_BANK;
  wire enWr = regWr && regAddr == `FSOAM_REG_IRQ_EN;
  // Sector count limit of the selected layout and density
  assign lim = (cfg_q[2:1] >= 2'h2) ? (cfg_q[3] ? 10'h080 : 10'h040) :
    (cfg_q[3] ? 10'h21E : 10'h11E);

  // Track configuration, bank and enable writes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfgSeen_q <= 1'b0;
      bankSeen_q <= 1'b0;
      cfg_q <= 4'hC;
      en_q <= 4'h0;
    end else begin
      cfgSeen_q <= cfgSeen_q | cfgWr;
      bankSeen_q <= bankSeen_q | bankWr;
      cfg_q <= cfgWr ? regWrData[3:0] : cfg_q;
      en_q <= enWr ? regWrData[3:0] : en_q;
    end
  end

  // ====
  // Properties
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  property p_bankRst;
    regRd && regAddr == `FSOAM_REG_BANK && !bankSeen_q |=> regRdData == 32'h0;
  endproperty
  a_bankRst: assert property (p_bankRst) else $error("bank not zero");
  property p_cfgRst;
    regRd && regAddr == `FSOAM_REG_CONFIG && !cfgSeen_q |=>
      regRdData[3:0] == 4'hC;
  endproperty
  a_cfgRst: assert property (p_cfgRst) else $error("config default");
  property p_sectLim;
    regRd && regAddr == `FSOAM_REG_LAST_SECT |=> regRdData < {22'h0, lim};
  endproperty
  a_sectLim: assert property (p_sectLim) else $error("sector range");
  property p_irqLvl;
    regRd && regAddr == `FSOAM_REG_IRQ_STAT |=>
      irq == |(regRdData[3:0] & en_q);
  endproperty
  a_irqLvl: assert property (p_irqLvl) else $error("irq level");
  property p_enOff;
    enWr && regWrData[3:0] == 4'h0 |-> ##3 !irq;
  endproperty
  a_enOff: assert property (p_enOff) else $error("irq not masked");
  property p_rdIdle;
    !$past(regRd) |-> regRdData == 32'h0;
  endproperty
  a_rdIdle: assert property (p_rdIdle) else $error("read data idle");
  property p_oeWhole;
    ioOe == 8'h00 || ioOe == 8'hFF;
  endproperty
  a_oeWhole: assert property (p_oeWhole) else $error("split enable");
  property p_oeRel;
    csPinN [*6] |-> ioOe == 8'h00;
  endproperty
  a_oeRel: assert property (p_oeRel) else $error("lines not freed");
  c_irq: cover property ($rose(irq));
  c_oe: cover property (ioOe == 8'hFF);
  c_sect: cover property (regRd && regAddr == `FSOAM_REG_LAST_SECT);
endmodule

bind fsoam_top fsoam_checker fsoam_checker_i (
  .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
  .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sckPin(sckPin),
  .csPinN(csPinN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .irq(irq)
);

// ---- tb/fsoam_host.sv ----
// Host link controller model that issues framed commands
`timescale 1ns/100ps

module fsoam_host (
  input wire logic clk,
  input wire logic [7:0] ioOut,
  input wire logic [7:0] ioOe,
  output logic sckPin,
  output logic csPinN,
  output logic [7:0] ioIn
);
  logic [7:0] oeSeen;

  // Idle link: clock still, frame deselected
  initial begin
    sckPin = 1'b0;
    csPinN = 1'b1;
    ioIn = 8'h5A;
    oeSeen = 8'h00;
  end

  // One byte in 8 clocks; device byte taken mid high phase
  task automatic xfer(input logic [7:0] d, output logic [7:0] q);
    ioIn[3:0] <= d[3:0];
    ioIn[7:4] <= d[7:4];
    repeat (4) @(posedge clk);
    sckPin <= 1'b1;
    repeat (2) @(posedge clk);
    q = ioOut;
    oeSeen = ioOe;
    repeat (2) @(posedge clk);
    sckPin <= 1'b0;
  endtask

  // Opcode, optional 3 address bytes, then one data byte
  task automatic frame(input logic [7:0] op, input logic [23:0] a,
    input logic hasAddr, input logic [7:0] d, output logic [7:0] q);
    csPinN <= 1'b0;
    repeat (4) @(posedge clk);
    xfer(op, q);
    if (hasAddr) begin
      xfer(a[23:16], q);
      xfer(a[15:8], q);
      xfer(a[7:0], q);
    end
    xfer(d, q);
    csPinN <= 1'b1;
    ioIn <= ~ioIn; // Released lines lose the last byte
    repeat (6) @(posedge clk);
  endtask
endmodule

// ---- tb/tb_flash_sector_otp_address_map.sv ----
// Self-checking bench for the flash sector and OTP address map
`timescale 1ns/100ps
`include "fsoam_defs.svh"

module tb_flash_sector_otp_address_map;
  // Copy of the design's default random number; value is arbitrary
  localparam logic [127:0] RND = 128'h0123456789ABCDEFFEDCBA9876543210;
  // Rows: config, bank, 24-bit address, expected sector index
  localparam logic [45:0] ROWS [13] = '{
    {4'hC, 8'h00, 24'h07FFFF, 10'h000}, {4'hC, 8'h00, 24'h080000, 10'h001},
    {4'hE, 8'h00, 24'h080000, 10'h001}, {4'h8, 8'h00, 24'h03E000, 10'h01F},
    {4'h8, 8'h00, 24'h040000, 10'h020}, {4'h8, 8'h00, 24'h060000, 10'h021},
    {4'hA, 8'h00, 24'h020000, 10'h001}, {4'hA, 8'h03, 24'hFC0000, 10'h1FE},
    {4'hA, 8'h03, 24'hFFE000, 10'h21D}, {4'h2, 8'h01, 24'hFC0000, 10'h0FE},
    {4'h2, 8'h01, 24'hFFFFFF, 10'h11D}, {4'h4, 8'h01, 24'hFFFFFF, 10'h03F},
    {4'h0, 8'h01, 24'hFFFFFF, 10'h11D}};
  logic clk, rst, regWr, regRd, irq, sckPin, csPinN;
  logic [3:0] regAddr;
  logic [31:0] regWrData, regRdData, rd;
  logic [7:0] ioIn, ioOut, ioOe, q;
  int errCount, comparisons;

  fsoam_top fsoam_top_i (
    .clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sckPin(sckPin),
    .csPinN(csPinN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe), .irq(irq));
  fsoam_host fsoam_host_i (
    .clk(clk), .ioOut(ioOut), .ioOe(ioOe), .sckPin(sckPin),
    .csPinN(csPinN), .ioIn(ioIn));

  // ====
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    repeat (20000) @(posedge clk);
    errCount++;
    conclude();
  end

  // ====
  // Bus, link and compare tasks
  task automatic wrReg(input logic [3:0] a, input logic [31:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rdReg(input logic [3:0] a, output logic [31:0] d);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    d = regRdData;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errCount++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic fr(input logic [7:0] op, input logic [23:0] a,
    input logic h, input logic [7:0] d);
    fsoam_host_i.frame(op, a, h, d, q);
  endtask
  task automatic progExp(input logic [10:0] a, input logic [7:0] d,
    input logic err);
    fr(`FSOAM_OP_OTP_PROG, {13'h0, a}, 1'b1, d);
    rdReg(`FSOAM_REG_STATUS, rd);
    chk(rd, {31'h0, err});
    fr(`FSOAM_OP_CLR_STATUS, 24'h0, 1'b0, 8'hFF);
  endtask
  task automatic otpRd(input logic [10:0] a, input logic [7:0] e);
    fr(`FSOAM_OP_OTP_READ, {13'h0, a}, 1'b1, 8'hFF);
    chk({24'h0, q}, {24'h0, e});
  endtask
  task automatic irqIs(input logic e);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, {31'h0, e});
  endtask
  task automatic conclude();
    $display("comparisons %0d, mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // ====
  // Main sequence
  initial begin
    {rst, regWr, regRd, regAddr, regWrData} = {1'b1, 38'h0};
    errCount = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    foreach (ROWS[i]) begin
      wrReg(`FSOAM_REG_CONFIG, {28'h0, ROWS[i][45:42]});
      wrReg(`FSOAM_REG_BANK, {24'h0, ROWS[i][41:34]});
      fr(`FSOAM_OP_ERASE, ROWS[i][33:10], 1'b1, 8'hFF);
      rdReg(`FSOAM_REG_LAST_SECT, rd);
      chk(rd, {22'h0, ROWS[i][9:0]});
      rdReg(`FSOAM_REG_STATUS, rd);
      chk(rd, 32'h0);
    end
    $display("sector rows done");
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    rdReg(`FSOAM_REG_CONFIG, rd);
    chk(rd, 32'hC);
    rdReg(`FSOAM_REG_BANK, rd);
    chk(rd, 32'h0);
    rdReg(4'h9, rd);
    chk(rd, 32'h0);
    $display("reset done");
    otpRd(11'h000, RND[7:0]);
    otpRd(11'h00F, RND[127:120]);
    otpRd(11'h010, `FSOAM_ERASED_BYTE);
    otpRd(11'h01F, 8'hFF);
    otpRd(11'h7FF, 8'hFF);
    wrReg(`FSOAM_REG_IRQ_EN, 32'h2);
    progExp(11'h000, 8'h00, 1'b1);
    otpRd(11'h000, RND[7:0]);
    rdReg(`FSOAM_REG_IRQ_STAT, rd);
    chk(rd & 32'h2, 32'h2);
    irqIs(1'b1);
    wrReg(`FSOAM_REG_IRQ_EN, 32'h0);
    irqIs(1'b0);
    wrReg(`FSOAM_REG_IRQ_EN, 32'h2);
    irqIs(1'b1);
    wrReg(`FSOAM_REG_IRQ_CLR, 32'hF);
    irqIs(1'b0);
    fr(`FSOAM_OP_OTP_PROG, 24'h000800, 1'b1, 8'h00);
    rdReg(`FSOAM_REG_STATUS, rd);
    chk(rd, 32'h1);
    fr(`FSOAM_OP_CLR_STATUS, 24'h0, 1'b0, 8'hFF);
    progExp(11'h014, 8'h5A, 1'b0);
    otpRd(11'h014, 8'h5A);
    progExp(11'h020, 8'hF0, 1'b0);
    progExp(11'h010, 8'hDD, 1'b0);
    progExp(11'h020, 8'h00, 1'b1);
    otpRd(11'h020, 8'hF0);
    progExp(11'h015, 8'h00, 1'b0);
    progExp(11'h013, 8'h77, 1'b0);
    progExp(11'h3E0, 8'h00, 1'b1);
    progExp(11'h3C0, 8'h00, 1'b0);
    progExp(11'h7E0, 8'h00, 1'b0);
    wrReg(`FSOAM_REG_CONFIG, 32'hD);
    progExp(11'h040, 8'h00, 1'b1);
    wrReg(`FSOAM_REG_CONFIG, 32'hC);
    progExp(11'h040, 8'h33, 1'b0);
    otpRd(11'h040, 8'h33);
    $display("otp done");
    wrReg(`FSOAM_REG_PROT, 32'h8000_0000);
    fr(`FSOAM_OP_PROG, 24'h000010, 1'b1, 8'h00);
    rdReg(`FSOAM_REG_STATUS, rd);
    chk(rd, 32'h1);
    fr(`FSOAM_OP_ERASE, 24'h001000, 1'b1, 8'hFF);
    rdReg(`FSOAM_REG_STATUS, rd);
    chk(rd, 32'h3);
    wrReg(`FSOAM_REG_BANK, 32'h100);
    fr(`FSOAM_OP_ERASE, 24'h000800, 1'b1, 8'h00);
    rdReg(`FSOAM_REG_LAST_SECT, rd);
    chk(rd, 32'h1);
    fr(`FSOAM_OP_ID_READ, 24'h0, 1'b0, 8'hFF);
    chk({24'h0, fsoam_host_i.oeSeen}, 32'hFF);
    $display("protection and id done");
    conclude();
  end
endmodule
